// File: design/shp_host_port.sv
// Purpose: Slave serial host port giving an outside master access to registers.
// Assumes: SCLK far slower than MCLK_IN; register read data valid during REG_RD_OUT.
// Notes: Two-wire or three-wire mode is chosen by straps caught after reset.
//
// Function
// - Strap 7 high selects three-wire protocol, low selects two-wire.
// - Strap levels are caught on the third clock edge after reset release and held until next reset.
// - Two-wire slave address comes from straps 6 down to 0.
// - Three-wire mode ignores straps 4 down to 0.
// - Three-wire strap 5 high drives data actively, low makes it open-drain.
// - Three-wire strap 6 high transmits on falling, samples on rising clock.
// - Three-wire adds active-low chip select; two-wire uses clock and data only.
// - Two-wire device is slave only; master makes the clock.
// - Data falling while clock high starts a new transfer.
// - Stop or repeated start ends the current transfer.
// - Transfers are whole bytes, most significant bit first, unlimited count.
// - After eighth bit, receiver pulls data low in the acknowledge slot.
// - Addressed device acknowledges every byte it receives.
// - Order is slave address, instruction, register address, then data.
// - Device answers only when first seven bits equal strapped address.
// - Last address bit low means master writes, high means master reads.
// - Instruction bits 1 and 0 become register address bits 9 and 8.
// - Opcodes 0001, 0010, 1001, 1010 are write/read with or without increment.
// - Register address byte gives low eight bits of ten-bit address.
// - Auto-increment advances pointer per byte; stop leaves it at next address.
// - Read writes address, repeated start, read address byte, master nacks last.

`timescale 1ns/1ps

module shp_host_port
(
   input logic MCLK_IN,
   input logic RESETN_IN,
   input logic [shp_pkg::STRAP_W-1:0] CONFIG_STRAP_PINS_IN,
   input logic SCLK_IN,
   input logic SERIAL_DATA_LINE_IN,
   output logic SERIAL_DATA_LINE_OUT,
   output logic SERIAL_DATA_LINE_OE_OUT,
   input logic CHIP_SELECT_N_IN,
   output logic [shp_pkg::REG_ADDR_W-1:0] REG_ADDR_OUT,
   output logic [shp_pkg::BYTE_W-1:0] REG_WDATA_OUT,
   output logic REG_WR_OUT,
   output logic REG_RD_OUT,
   input logic [shp_pkg::BYTE_W-1:0] REG_RDATA_IN,
   output logic THREE_WIRE_MODE_OUT,
   output logic STRAPS_VALID_OUT,
   output logic BUSY_OUT
);
   import shp_pkg::*;

   logic [STRAP_W-1:0] strap_s;
   logic scl_s;
   logic sda_s;
   logic cs_s;
   logic [STRAP_W-1:0] strap_q, strap_d;
   logic [1:0] strap_cnt_q, strap_cnt_d;
   logic strap_done_q, strap_done_d;
   shp_state_t state_q, state_d;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [BYTE_W-1:0] tx_q, tx_d;
   logic [3:0] cmd_q, cmd_d;
   logic [REG_ADDR_HI_W-1:0] ptr_hi_q, ptr_hi_d;
   logic [REG_ADDR_W-1:0] ptr_q, ptr_d;
   logic [BYTE_W-1:0] wdata_q, wdata_d;
   logic wr_q, wr_d;
   logic rd_q, rd_d;
   logic ack_pend_q, ack_pend_d;
   logic drv_en_q, drv_en_d;
   logic drv_bit_q, drv_bit_d;
   logic sda_out_q, sda_out_d;
   logic sda_oe_q, sda_oe_d;
   logic busy_q, busy_d;
   logic scl_p_q;
   logic sda_p_q;
   logic three_wire;
   logic active_drive;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sample_edge;
   logic drive_edge;
   logic run;
   logic byte_evt;
   logic addr_match;
   logic cmd_inc;
   logic cmd_wr;
   logic cmd_rd;
   logic [BYTE_W-1:0] rx_byte;

   // ************************************************************
   // Input synchronisation
   // ************************************************************
   // two-stage synchronisers
   shp_sync
   #(
      .WIDTH(SYNC_W),
      .RESET_VAL(SYNC_RESET)
   )
   u_sync
   (
      .clk_in(MCLK_IN),
      .resetn_in(RESETN_IN),
      .d_in({CONFIG_STRAP_PINS_IN, SCLK_IN, SERIAL_DATA_LINE_IN, CHIP_SELECT_N_IN}),
      .q_out({strap_s, scl_s, sda_s, cs_s})
   );

   // ************************************************************
   // Strap capture
   // ************************************************************
   // The synchroniser is let fill with post-reset pin levels before capture.
   always_comb
   begin
      strap_d = strap_q;
      strap_cnt_d = strap_cnt_q;
      strap_done_d = strap_done_q;
      if (!strap_done_q)
      begin
         if (strap_cnt_q == STRAP_SETTLE_CYC)
         begin
            strap_d = strap_s;
            strap_done_d = 1'b1;
         end
         else
         begin
            strap_cnt_d = strap_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         strap_q <= '0;
         strap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
      end
      else
      begin
         strap_q <= strap_d;
         strap_cnt_q <= strap_cnt_d;
         strap_done_q <= strap_done_d;
      end
   end

   // ************************************************************
   // Line events and command decode
   // ************************************************************
   // mode select
   assign three_wire = strap_q[STRAP_MODE_BIT];
   assign active_drive = three_wire && strap_q[STRAP_DRIVE_BIT];
   assign scl_rise = scl_s && !scl_p_q;
   assign scl_fall = !scl_s && scl_p_q;
   assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign sample_edge = three_wire ? (strap_q[STRAP_EDGE_BIT] ? scl_rise : scl_fall) : scl_rise;
   assign drive_edge = three_wire ? (strap_q[STRAP_EDGE_BIT] ? scl_fall : scl_rise) : scl_fall;
   assign run = strap_done_q && (three_wire ? (!cs_s && state_q != ST_IDLE) : 1'b1);
   assign byte_evt = run && sample_edge && (bit_cnt_q == BIT_LAST);
   assign rx_byte = {shift_q[BYTE_W-2:0], sda_s};
   assign addr_match = (rx_byte[BYTE_W-1:1] == strap_q[DEV_ADDR_W-1:0]);
   assign cmd_inc = (cmd_q == OP_WR_INC) || (cmd_q == OP_RD_INC);
   assign cmd_wr = (cmd_q == OP_WR_INC) || (cmd_q == OP_WR_NOINC);
   assign cmd_rd = (cmd_q == OP_RD_INC) || (cmd_q == OP_RD_NOINC);

   // ************************************************************
   // Transfer engine
   // ************************************************************
   always_comb
   begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      tx_d = tx_q;
      cmd_d = cmd_q;
      ptr_hi_d = ptr_hi_q;
      ptr_d = ptr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      ack_pend_d = ack_pend_q;
      drv_en_d = drv_en_q;
      drv_bit_d = drv_bit_q;
      if (rd_q)
      begin
         tx_d = REG_RDATA_IN;
      end
      if (wr_q && cmd_inc)
      begin
         ptr_d = ptr_q + PTR_STEP;
      end
      if (strap_done_q && three_wire && cs_s)
      begin
         state_d = ST_IDLE;
         drv_en_d = 1'b0;
      end
      else if (strap_done_q && three_wire && state_q == ST_IDLE)
      begin
         state_d = ST_INSTR;
         bit_cnt_d = 4'h0;
      end
      else if (strap_done_q && !three_wire && start_det)
      begin
         state_d = ST_DEV_ADDR;
         bit_cnt_d = 4'h0;
         ack_pend_d = 1'b0;
         drv_en_d = 1'b0;
      end
      else if (strap_done_q && !three_wire && stop_det)
      begin
         state_d = ST_IDLE;
         ack_pend_d = 1'b0;
         drv_en_d = 1'b0;
      end
      else if (run)
      begin
         if (drive_edge)
         begin
            if (state_q == ST_RD_DATA && !bit_cnt_q[3])
            begin
               drv_en_d = 1'b1;
               drv_bit_d = tx_q[~bit_cnt_q[2:0]];
            end
            else if (ack_pend_q)
            begin
               drv_en_d = 1'b1;
               drv_bit_d = 1'b0;
               ack_pend_d = 1'b0;
            end
            else
            begin
               drv_en_d = 1'b0;
            end
         end
         if (sample_edge && bit_cnt_q == ACK_SLOT)
         begin
            bit_cnt_d = 4'h0;
            // The slot after the read address byte holds our own acknowledge, not the master's.
            if (state_q == ST_RD_DATA && !drv_en_q)
            begin
               if (cmd_inc)
               begin
                  ptr_d = ptr_q + PTR_STEP;
               end
               if (sda_s)
               begin
                  state_d = ST_IGNORE;
               end
               else
               begin
                  rd_d = 1'b1;
               end
            end
         end
         else if (sample_edge)
         begin
            shift_d = rx_byte;
            bit_cnt_d = (byte_evt && three_wire) ? 4'h0 : bit_cnt_q + 4'h1;
            if (byte_evt)
            begin
               case (state_q)
                  ST_DEV_ADDR:
                  begin
                     if (addr_match)
                     begin
                        ack_pend_d = 1'b1;
                        state_d = rx_byte[0] ? ST_RD_DATA : ST_INSTR;
                        rd_d = rx_byte[0];
                     end
                     else
                     begin
                        state_d = ST_IGNORE;
                     end
                  end
                  ST_INSTR:
                  begin
                     cmd_d = rx_byte[BYTE_W-1:OPCODE_LSB];
                     ptr_hi_d = rx_byte[REG_ADDR_HI_W-1:0];
                     ack_pend_d = !three_wire;
                     state_d = ST_REG_ADDR;
                  end
                  ST_REG_ADDR:
                  begin
                     ptr_d = {ptr_hi_q, rx_byte};
                     ack_pend_d = !three_wire;
                     state_d = (three_wire && cmd_rd) ? ST_RD_DATA : ST_WR_DATA;
                     rd_d = three_wire && cmd_rd;
                  end
                  ST_WR_DATA:
                  begin
                     wdata_d = rx_byte;
                     wr_d = cmd_wr;
                     ack_pend_d = !three_wire;
                  end
                  ST_RD_DATA:
                  begin
                     if (three_wire)
                     begin
                        rd_d = 1'b1;
                        ptr_d = cmd_inc ? ptr_q + PTR_STEP : ptr_q;
                     end
                  end
                  default:
                  begin
                     state_d = state_q;
                  end
               endcase
            end
         end
      end
      sda_oe_d = drv_en_d && (active_drive || !drv_bit_d);
      sda_out_d = active_drive && drv_bit_d;
      busy_d = (state_d != ST_IDLE);
   end

   always_ff @(posedge MCLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= '0;
         tx_q <= '0;
         cmd_q <= OP_RESET;
         ptr_hi_q <= '0;
         ptr_q <= PTR_RESET;
         wdata_q <= '0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ack_pend_q <= 1'b0;
         drv_en_q <= 1'b0;
         drv_bit_q <= 1'b0;
         sda_out_q <= 1'b0;
         sda_oe_q <= 1'b0;
         busy_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         cmd_q <= cmd_d;
         ptr_hi_q <= ptr_hi_d;
         ptr_q <= ptr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         ack_pend_q <= ack_pend_d;
         drv_en_q <= drv_en_d;
         drv_bit_q <= drv_bit_d;
         sda_out_q <= sda_out_d;
         sda_oe_q <= sda_oe_d;
         busy_q <= busy_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign SERIAL_DATA_LINE_OUT = sda_out_q;
   assign SERIAL_DATA_LINE_OE_OUT = sda_oe_q;
   assign REG_ADDR_OUT = ptr_q;
   assign REG_WDATA_OUT = wdata_q;
   assign REG_WR_OUT = wr_q;
   assign REG_RD_OUT = rd_q;
   assign THREE_WIRE_MODE_OUT = strap_q[STRAP_MODE_BIT];
   assign STRAPS_VALID_OUT = strap_done_q;
   assign BUSY_OUT = busy_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   a_strap_hold:
   assert property (strap_done_q |=> strap_done_q && $stable(strap_q))
      else $error("Strap configuration changed after capture.");
   a_three_cs_start:
   assert property (strap_done_q && three_wire && !cs_s && state_q == ST_IDLE
                    |=> state_q == ST_INSTR && bit_cnt_q == 4'h0)
      else $error("Chip select did not open an instruction byte.");
   a_two_start:
   assert property (strap_done_q && !three_wire && start_det
                    |=> state_q == ST_DEV_ADDR && bit_cnt_q == 4'h0 && !sda_oe_q)
      else $error("Start condition did not restart address reception.");
   a_stop_release:
   assert property (strap_done_q && !three_wire && stop_det
                    |=> state_q == ST_IDLE && !sda_oe_q)
      else $error("Stop condition did not end the transfer.");
   a_open_drain:
   assert property (!active_drive |-> !sda_out_q)
      else $error("Open-drain line driven high.");
   a_drive_edge:
   assert property ($rose(sda_oe_q) |-> $past(drive_edge))
      else $error("Data line driven outside the transmit edge.");
   a_ack_match:
   assert property (byte_evt && state_q == ST_DEV_ADDR && !three_wire && addr_match
                    |=> ack_pend_q ##0 sda_oe_q == 1'b0)
      else $error("Matching address not acknowledged.");
   a_nomatch_quiet:
   assert property (byte_evt && state_q == ST_DEV_ADDR && !three_wire && !addr_match
                    |=> state_q == ST_IGNORE && !ack_pend_q && !sda_oe_q)
      else $error("Unmatched address was answered.");
   a_ptr_load:
   assert property (byte_evt && state_q == ST_REG_ADDR
                    |=> REG_ADDR_OUT == {$past(ptr_hi_q), $past(rx_byte)})
      else $error("Register pointer not loaded from address bytes.");
   a_wr_autoinc:
   assert property (REG_WR_OUT && cmd_inc |=> REG_ADDR_OUT == $past(REG_ADDR_OUT) + PTR_STEP)
      else $error("Write pointer did not advance.");
   a_ack_steady:
   assert property (!three_wire && sda_oe_q && !drive_edge && !start_det && !stop_det
                    |=> sda_oe_q)
      else $error("Acknowledge released before the clock fell.");
   a_rd_fetch:
   assert property (byte_evt && state_q == ST_DEV_ADDR && !three_wire && addr_match && sda_s
                    |=> REG_RD_OUT && state_q == ST_RD_DATA)
      else $error("Read address byte did not fetch data.");

   c_two_wire_write: cover property (REG_WR_OUT && !three_wire);
   c_two_wire_read: cover property (REG_RD_OUT && !three_wire);
   c_three_wire_read: cover property (REG_RD_OUT && three_wire);
   c_read_nack_end: cover property (state_q == ST_RD_DATA ##1 state_q == ST_IGNORE);

endmodule

// File: include/shp_pkg.sv
// Purpose: Shared constants and types of the serial host register port.
// Assumes: Eight configuration straps, ten-bit register address, byte data.
// Notes: Every offset, field position and count, and the pointer, opcode and synchroniser reset values, live here.

package shp_pkg;

   // ************************************************************
   // Strap layout
   // ************************************************************
   localparam int STRAP_W = 8;
   localparam int STRAP_MODE_BIT = 7;
   localparam int STRAP_EDGE_BIT = 6;
   localparam int STRAP_DRIVE_BIT = 5;
   localparam int DEV_ADDR_W = 7;
   localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

   // ************************************************************
   // Framing
   // ************************************************************
   localparam int BYTE_W = 8;
   localparam int REG_ADDR_W = 10;
   localparam int REG_ADDR_HI_W = 2;
   localparam int OPCODE_LSB = 4;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [REG_ADDR_W-1:0] PTR_RESET = 10'h000;
   localparam logic [REG_ADDR_W-1:0] PTR_STEP = 10'h001;

   // ************************************************************
   // Instruction opcodes, upper nibble of the instruction byte
   // ************************************************************
   localparam logic [3:0] OP_WR_INC = 4'h1;
   localparam logic [3:0] OP_WR_NOINC = 4'h2;
   localparam logic [3:0] OP_RD_INC = 4'h9;
   localparam logic [3:0] OP_RD_NOINC = 4'hA;
   localparam logic [3:0] OP_RESET = 4'h0;

   // ************************************************************
   // Synchroniser: straps, clock, data, chip select
   // ************************************************************
   localparam int SYNC_W = STRAP_W + 3;
   localparam logic [SYNC_W-1:0] SYNC_RESET = {{STRAP_W{1'b0}}, 3'h7};

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV_ADDR,
      ST_INSTR,
      ST_REG_ADDR,
      ST_WR_DATA,
      ST_RD_DATA,
      ST_IGNORE
   } shp_state_t;

endpackage

// File: design/shp_sync.sv
// Purpose: Two flip-flop synchroniser for inputs from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read by the second stage only.

`timescale 1ns/1ps

module shp_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input logic clk_in,
   input logic resetn_in,
   input logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stage_q;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         meta_q <= RESET_VAL;
         stage_q <= RESET_VAL;
      end
      else
      begin
         meta_q <= d_in;
         stage_q <= meta_q;
      end
   end

   assign q_out = stage_q;

endmodule

// File: tb/shp_host_model.sv
// Purpose: Behavioural serial bus master driving the host port from outside.
// Assumes: Link period 64 ns; data pin is open drain with a pull-up.
// Notes: Tasks are called by the testbench through the instance.

`timescale 1ns/1ps

module shp_host_model
(
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out,
   output logic cs_n_out
);
   // ************************************************************
   // Bus master tasks
   // ************************************************************
   // master alone makes the clock.
   initial
   begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
      cs_n_out = 1'b1;
   end

   task automatic start_cond();
      sda_pull_out = 1'b0;
      #32 scl_out = 1'b1;
      #16 sda_pull_out = 1'b1;
      #16 scl_out = 1'b0;
      #16;
   endtask

   task automatic stop_cond();
      sda_pull_out = 1'b1;
      #16 scl_out = 1'b1;
      #16 sda_pull_out = 1'b0;
      #32;
   endtask

   // data changes only while clock low.
   task automatic put_bit(input logic b, output logic r);
      sda_pull_out = ~b;
      #16 scl_out = 1'b1;
      #32 r = sda_in;
      scl_out = 1'b0;
      #16;
   endtask

   task automatic xfer(input logic [7:0] tx, input logic ack_slot, input logic ack_tx,
                       output logic [7:0] rx, output logic ack_rx);
      logic r;
      ack_rx = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         put_bit(tx[i], r);
         rx[i] = r;
      end
      if (ack_slot)
      begin
         put_bit(~ack_tx, r);
         ack_rx = ~r;
      end
   endtask

   // chip select frames a three-wire transfer.
   task automatic select(input logic on);
      scl_out = 1'b0;
      #16 cs_n_out = ~on;
      #16;
   endtask
endmodule

// File: tb/test_shp_host_port.sv
// Purpose: Self-checking bench of the serial host register port.
// Assumes: Register file reply is a fixed function of the pointer.
// Notes: Two-wire tests first, three-wire last, each three-wire test after its own reset.

`timescale 1ns/1ps

module test_shp_host_port;
   import shp_pkg::*;
   // ************************************************************
   // Bench wiring
   // ************************************************************
   localparam logic [6:0] DEV = 7'h5A;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] straps = 8'h5A;
   logic scl, pull, cs_n, sda, sdo, oe, wr, rd, mode, valid, busy;
   logic drove_high = 1'b0;
   logic [9:0] addr;
   logic [7:0] wdata, rdata;
   logic [17:0] wlog [$];
   int error_cnt = 0;
   int n_tests = 0;

   always #2.5 mclk = ~mclk;
   assign sda = oe ? (sdo & ~pull) : ~pull;
   assign rdata = rexp(addr);

   shp_host_port dut_u
   (
      .MCLK_IN(mclk), .RESETN_IN(resetn), .CONFIG_STRAP_PINS_IN(straps),
      .SCLK_IN(scl), .SERIAL_DATA_LINE_IN(sda), .SERIAL_DATA_LINE_OUT(sdo),
      .SERIAL_DATA_LINE_OE_OUT(oe),
      .CHIP_SELECT_N_IN(cs_n), .REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdata),
      .REG_WR_OUT(wr), .REG_RD_OUT(rd), .REG_RDATA_IN(rdata),
      .THREE_WIRE_MODE_OUT(mode), .STRAPS_VALID_OUT(valid), .BUSY_OUT(busy)
   );

   shp_host_model host_u(.sda_in(sda), .scl_out(scl), .sda_pull_out(pull), .cs_n_out(cs_n));

   always @(negedge mclk)
   begin
      if (wr === 1'b1)
         wlog.push_back({addr, wdata});
      if (oe === 1'b1 && sdo === 1'b1)
         drove_high <= 1'b1;
   end

   function automatic logic [7:0] rexp(input logic [9:0] a);
      return a[7:0] ^ {6'h00, a[9:8]};
   endfunction

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic do_reset(input logic [7:0] s);
      int n;
      @(negedge mclk);
      resetn = 1'b0;
      straps = s;
      repeat (6) @(negedge mclk);
      resetn = 1'b1;
      for (n = 0; n < 50 && valid !== 1'b1; n++)
         @(negedge mclk);
      check(valid, 1'b1, "straps valid");
      if (n >= 50)
         tally_and_finish();
      repeat (6) @(negedge mclk);
   endtask

   task automatic wbyte(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic a;
      host_u.xfer(b, 1'b1, 1'b0, rx, a);
      check(a, exp_ack, "ack");
   endtask

   task automatic rbyte(input logic [9:0] a, input logic last);
      logic [7:0] rx;
      logic k;
      host_u.xfer(8'hFF, 1'b1, ~last, rx, k);
      check(rx, rexp(a), "read data");
   endtask

   task automatic head(input logic [7:0] instr, input logic [7:0] ra);
      wlog.delete();
      host_u.start_cond();
      wbyte({DEV, 1'b0}, 1'b1);
      wbyte(instr, 1'b1);
      wbyte(ra, 1'b1);
   endtask

   task automatic finish_frame(input int nwr, input logic [9:0] ptr);
      host_u.stop_cond();
      repeat (8) @(negedge mclk);
      check(wlog.size(), nwr, "write count");
      check(addr, ptr, "pointer");
      check(busy, 1'b0, "busy after stop");
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_straps();
      straps = 8'hFF;
      repeat (10) @(negedge mclk);
      check(mode, 1'b0, "mode held");
      $display("test straps done");
   endtask

   task automatic t_write_inc();
      head({OP_WR_INC, 4'hE}, 8'hFE);
      wbyte(8'h11, 1'b1);
      wbyte(8'h22, 1'b1);
      finish_frame(2, 10'h300);
      check(wlog[0], {10'h2FE, 8'h11}, "write 0");
      check(wlog[1], {10'h2FF, 8'h22}, "write 1");
      $display("test write_inc done");
   endtask

   task automatic t_write_noinc();
      head({OP_WR_NOINC, 4'hD}, 8'h10);
      wbyte(8'h33, 1'b1);
      wbyte(8'h44, 1'b1);
      finish_frame(2, 10'h110);
      check(wlog[1], {10'h110, 8'h44}, "write same");
      $display("test write_noinc done");
   endtask

   task automatic t_read(input logic [3:0] op, input logic [9:0] a0, input logic [9:0] a1);
      head({op, 2'b11, a0[9:8]}, a0[7:0]);
      host_u.start_cond();
      wbyte({DEV, 1'b1}, 1'b1);
      rbyte(a0, 1'b0);
      rbyte(a1, 1'b1);
      finish_frame(0, (op == OP_RD_INC) ? a1 + 10'h001 : a1);
      check(drove_high, 1'b0, "open drain");
      $display("test read %h done", op);
   endtask

   task automatic t_mismatch();
      wlog.delete();
      host_u.start_cond();
      wbyte({7'h5B, 1'b0}, 1'b0);
      wbyte({OP_WR_INC, 4'hF}, 1'b0);
      wbyte(8'h00, 1'b0);
      finish_frame(0, 10'h381);
      $display("test mismatch done");
   endtask

   task automatic t_three_wire(input logic [7:0] s, input logic exp_hi);
      logic [7:0] rx;
      logic a;
      do_reset(s);
      check(mode, 1'b1, "three-wire mode");
      wlog.delete();
      host_u.select(1'b1);
      host_u.xfer({OP_WR_INC, 4'hD}, 1'b0, 1'b0, rx, a);
      host_u.xfer(8'h20, 1'b0, 1'b0, rx, a);
      host_u.xfer(8'h77, 1'b0, 1'b0, rx, a);
      host_u.select(1'b0);
      host_u.select(1'b1);
      host_u.xfer({OP_RD_NOINC, 4'hF}, 1'b0, 1'b0, rx, a);
      host_u.xfer(8'h81, 1'b0, 1'b0, rx, a);
      host_u.xfer(8'hFF, 1'b0, 1'b0, rx, a);
      host_u.select(1'b0);
      repeat (8) @(negedge mclk);
      check(wlog[0], {10'h120, 8'h77}, "three-wire write");
      check(rx, rexp(10'h381), "three-wire read");
      check(drove_high, exp_hi, "drive type");
      $display("test three_wire %h done", s);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial
   begin
      do_reset(8'h5A);
      t_straps();
      t_write_inc();
      t_write_noinc();
      t_read(OP_RD_INC, 10'h040, 10'h041);
      t_read(OP_RD_NOINC, 10'h381, 10'h381);
      t_mismatch();
      t_three_wire(8'h80, 1'b0);
      t_three_wire(8'hE5, 1'b1);
      tally_and_finish();
   end

   initial
   begin
      #200000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
